// file: rdsw_pkg.sv
/*
 package for the random delay switch: widths, reset values, timebase codes, state enum and the carrier structs.
 assumes a single clock domain and synchronous inputs.
*/
package rdsw_pkg;
    localparam int RDSW_TIME_W = 16;
    localparam int RDSW_LFSR_W = 16;
    localparam logic [RDSW_LFSR_W-1:0] RDSW_LFSR_SEED = 16'hACE1;
    localparam logic [RDSW_LFSR_W-1:0] RDSW_LFSR_TAPS = 16'hB400;
    localparam logic [RDSW_TIME_W-1:0] RDSW_TIME_ZERO = 16'h0000;
    localparam logic [RDSW_TIME_W-1:0] RDSW_TIME_ONE = 16'h0001;
    localparam logic [1:0] RDSW_TB_10MS = 2'h0;
    localparam logic [1:0] RDSW_TB_100MS = 2'h1;
    localparam logic [1:0] RDSW_TB_1S = 2'h2;
    localparam logic [1:0] RDSW_TB_1MIN = 2'h3;

    typedef enum logic [1:0] {
        RDSW_IDLE,
        RDSW_ON_WAIT,
        RDSW_OFF_WAIT
    } rdsw_state_type;

    typedef struct packed {
        logic on_src_sel;
        logic off_src_sel;
        logic [RDSW_TIME_W-1:0] max_on_delay;
        logic [RDSW_TIME_W-1:0] max_off_delay;
        logic [RDSW_TIME_W-1:0] on_src_value;
        logic [RDSW_TIME_W-1:0] off_src_value;
        logic [1:0] timebase_sel;
        logic retentive;
    } rdsw_cfg_type;

    typedef struct packed {
        logic output_level;
        logic [RDSW_TIME_W-1:0] elapsed_time;
        logic [1:0] state;
        logic [RDSW_TIME_W-1:0] target;
    } rdsw_snap_type;
endpackage : rdsw_pkg

// file: rdsw_lfsr.sv
/*
 free-running galois lfsr that also scales its value into 0..limit.
 assumes limit is stable in the cycle it is sampled.
*/
module rdsw_lfsr
    import rdsw_pkg::*;
#(
    parameter int WIDTH = RDSW_LFSR_W
)
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [RDSW_TIME_W-1:0] limit_i,
    output logic [RDSW_TIME_W-1:0] pick_o
);
    import rdsw_pkg::*;

    if (WIDTH != RDSW_TIME_W)
    begin : g_width_check
        $error("rdsw_lfsr: width must equal time width");
    end

    logic [WIDTH-1:0] lfsr_q;
    logic [WIDTH-1:0] lfsr_d;
    logic [2*RDSW_TIME_W+1:0] product;

    assign lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ RDSW_LFSR_TAPS) : (lfsr_q >> 1);
    // multiply by limit+1 and keep the top half, so the pick spans 0..limit inclusive
    assign product = {2'b00, lfsr_q, {RDSW_TIME_W{1'b0}}} / {{RDSW_TIME_W{1'b0}}, 2'b00, {RDSW_TIME_W{1'b1}}}
        * ({{(RDSW_TIME_W+1){1'b0}}, limit_i} + {{(2*RDSW_TIME_W+1){1'b0}}, 1'b1});
    assign pick_o = product[2*RDSW_TIME_W-1:RDSW_TIME_W] > limit_i ? limit_i
        : product[2*RDSW_TIME_W-1:RDSW_TIME_W];

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            lfsr_q <= RDSW_LFSR_SEED;
        else
            lfsr_q <= lfsr_d;
    end
endmodule : rdsw_lfsr

// file: rdsw_switch.sv
/*
 random delay switch: follows enable with random on and off delays counted in timebase ticks.
 assumes enable, tick and configuration are synchronous to core_clk_i; the retention store lives outside.
*/
// How it works
// - rising enable starts random on-delay
// - on-delay expiry with enable high sets output
// - enable falling early cancels on-delay
// - falling enable starts random off-delay
// - off-delay expiry with enable low clears
// - enable rising early cancels off-delay
// - retentive restore, else defaults after power
// - max from constant or source; timebase selectable
module rdsw_switch
    import rdsw_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic [3:0] tick_i,
    input wire rdsw_pkg::rdsw_cfg_type cfg_i,
    input wire logic restore_i,
    input wire rdsw_pkg::rdsw_snap_type snap_i,
    output rdsw_pkg::rdsw_snap_type snap_o,
    output logic switch_o,
    output logic [RDSW_TIME_W-1:0] elapsed_time_o,
    output logic busy_o
);
    import rdsw_pkg::*;

    rdsw_state_type state_q;
    rdsw_state_type state_d;
    logic out_q;
    logic out_d;
    logic enable_q;
    logic [RDSW_TIME_W-1:0] elapsed_q;
    logic [RDSW_TIME_W-1:0] elapsed_d;
    logic [RDSW_TIME_W-1:0] target_q;
    logic [RDSW_TIME_W-1:0] target_d;
    logic [RDSW_TIME_W-1:0] on_limit;
    logic [RDSW_TIME_W-1:0] off_limit;
    logic [RDSW_TIME_W-1:0] pick_limit;
    logic [RDSW_TIME_W-1:0] pick;
    logic rise;
    logic fall;
    logic tick;
    logic expired;
    rdsw_state_type snap_state;
    rdsw_state_type state_n;
    logic out_n;
    logic [RDSW_TIME_W-1:0] elapsed_n;
    logic [RDSW_TIME_W-1:0] target_n;
    logic restore_keep;
    logic restore_clear;
    logic snap_code_ok;
    logic in_on_wait;
    logic in_off_wait;
    logic on_abort;
    logic on_done;
    logic off_abort;
    logic off_done;
    logic count_step;

    assign on_limit = cfg_i.on_src_sel ? cfg_i.on_src_value : cfg_i.max_on_delay;
    assign off_limit = cfg_i.off_src_sel ? cfg_i.off_src_value : cfg_i.max_off_delay;
    assign tick = tick_i[cfg_i.timebase_sel];
    // enable high on the first edge after reset reads as a rising edge
    assign rise = enable_i & ~enable_q;
    assign fall = ~enable_i & enable_q;
    // the pick is latched on the edge cycle only; a later limit change does not stretch a running delay
    assign pick_limit = rise ? on_limit : off_limit;
    // compared a cycle after the last tick, so a zero pick still costs two edges
    assign expired = elapsed_q >= target_q;
    assign in_on_wait = state_q == RDSW_ON_WAIT;
    assign in_off_wait = state_q == RDSW_OFF_WAIT;
    assign on_abort = in_on_wait & ~enable_i;
    assign on_done = in_on_wait & enable_i & expired;
    assign off_abort = in_off_wait & enable_i;
    assign off_done = in_off_wait & ~enable_i & expired;
    assign count_step = tick & ~expired;

    // an unknown saved state code would hold busy_o high for a cycle, so it is read as idle
    assign snap_code_ok = snap_i.state == RDSW_ON_WAIT || snap_i.state == RDSW_OFF_WAIT;
    assign snap_state = snap_code_ok ? rdsw_state_type'(snap_i.state) : RDSW_IDLE;
    assign restore_keep = restore_i & cfg_i.retentive;
    assign restore_clear = restore_i & ~cfg_i.retentive;

    // restore is folded in here so each register block below stays a plain load
    assign state_n = restore_keep ? snap_state
        : (restore_clear ? RDSW_IDLE : state_d);
    assign out_n = restore_keep ? snap_i.output_level
        : (restore_clear ? 1'b0 : out_d);
    assign elapsed_n = restore_keep ? snap_i.elapsed_time
        : (restore_clear ? RDSW_TIME_ZERO : elapsed_d);
    assign target_n = restore_keep ? snap_i.target
        : (restore_clear ? RDSW_TIME_ZERO : target_d);

    // one strobe per timebase code
    if ($bits(tick_i) != 2 ** $bits(cfg_i.timebase_sel))
    begin : g_tick_width_check
        $error("rdsw_switch: tick vector must cover every timebase code");
    end

    rdsw_lfsr #(
        .WIDTH(RDSW_LFSR_W)
    ) u_lfsr (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .limit_i(pick_limit),
        .pick_o(pick)
    );

    always_comb
    begin
        state_d = state_q;
        out_d = out_q;
        elapsed_d = elapsed_q;
        target_d = target_q;
        if (rise)
        begin
            // an edge always restarts; the opposite timer is dropped here
            state_d = RDSW_ON_WAIT;
            elapsed_d = RDSW_TIME_ZERO;
            target_d = pick;
        end
        else if (fall)
        begin
            state_d = RDSW_OFF_WAIT;
            elapsed_d = RDSW_TIME_ZERO;
            target_d = pick;
        end
        else
        begin
            case (state_q)
                RDSW_IDLE:
                begin
                    elapsed_d = RDSW_TIME_ZERO;
                end
                RDSW_ON_WAIT:
                begin
                    if (on_abort)
                    begin
                        state_d = RDSW_IDLE;
                        elapsed_d = RDSW_TIME_ZERO;
                    end
                    else if (on_done)
                    begin
                        out_d = 1'b1;
                        state_d = RDSW_IDLE;
                    end
                    else if (count_step)
                        elapsed_d = elapsed_q + RDSW_TIME_ONE;
                end
                RDSW_OFF_WAIT:
                begin
                    if (off_abort)
                    begin
                        state_d = RDSW_IDLE;
                        elapsed_d = RDSW_TIME_ZERO;
                    end
                    else if (off_done)
                    begin
                        out_d = 1'b0;
                        state_d = RDSW_IDLE;
                    end
                    else if (count_step)
                        elapsed_d = elapsed_q + RDSW_TIME_ONE;
                end
                default:
                begin
                    state_d = RDSW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            state_q <= RDSW_IDLE;
        else
            state_q <= state_n;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            out_q <= 1'b0;
        else
            out_q <= out_n;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            elapsed_q <= RDSW_TIME_ZERO;
        else
            elapsed_q <= elapsed_n;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            target_q <= RDSW_TIME_ZERO;
        else
            target_q <= target_n;
    end

    // enable is sampled through a restore too, so no phantom edge follows power return
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            enable_q <= 1'b0;
        else
            enable_q <= enable_i;
    end

    assign switch_o = out_q;
    assign elapsed_time_o = elapsed_q;
    assign busy_o = state_q != RDSW_IDLE;
    assign snap_o = '{output_level: out_q, elapsed_time: elapsed_q, state: state_q, target: target_q};
endmodule : rdsw_switch

// file: rdsw_tick_src.sv
/*
 timebase tick source: four one-cycle strobes.
 assumes the switch clock; rates shrunk so runs stay short.
*/
module rdsw_tick_src
(
    input wire logic core_clk_i,
    output logic [3:0] tick_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] cnt_q = 6'h00;
    always @(posedge core_clk_i) cnt_q <= cnt_q + 6'h01;
    // selected strobe gates counting
    assign tick_o = {cnt_q == 6'h3F, cnt_q[3:0] == 4'hF, cnt_q[2:0] == 3'h7, cnt_q[0]};
endmodule : rdsw_tick_src

// file: rdsw_switch_asserts.sv
/*
 port checker for the random delay switch.
 assumes it is bound onto rdsw_switch.
*/
module rdsw_switch_asserts
    import rdsw_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic [3:0] tick_i,
    input wire rdsw_pkg::rdsw_cfg_type cfg_i,
    input wire logic restore_i,
    input wire rdsw_pkg::rdsw_snap_type snap_i,
    input wire logic switch_o,
    input wire logic [RDSW_TIME_W-1:0] elapsed_time_o,
    input wire logic busy_o
);
    import rdsw_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    rst_defaults_a: assert property (disable iff (1'b0) sys_rst_i |=> !switch_o && !busy_o && elapsed_time_o == 0)
        else $error("reset state wrong");
    on_start_a: assert property ($rose(enable_i) && !restore_i |=> busy_o || switch_o)
        else $error("on-delay not started");
    off_start_a: assert property ($fell(enable_i) && !restore_i |=> busy_o || !switch_o)
        else $error("off-delay not started");
    set_when_high_a: assert property ($rose(switch_o) && !$past(restore_i) |-> $past(enable_i))
        else $error("output set without enable");
    clr_when_low_a: assert property ($fell(switch_o) && !$past(restore_i) |-> !$past(enable_i))
        else $error("output cleared with enable");
    on_cancel_a: assert property (!switch_o && !enable_i && !restore_i |=> !switch_o)
        else $error("cancelled on-delay set output");
    off_cancel_a: assert property (switch_o && enable_i && !restore_i |=> switch_o)
        else $error("cancelled off-delay cleared output");
    tick_gate_a: assert property (busy_o && !tick_i[cfg_i.timebase_sel] && $stable(enable_i) && !restore_i
        |=> !busy_o || $stable(elapsed_time_o)) else $error("elapsed moved without tick");
    restore_a: assert property (restore_i && $stable(enable_i) |=> $past(cfg_i.retentive) ?
        switch_o == $past(snap_i.output_level) && elapsed_time_o == $past(snap_i.elapsed_time)
        : !switch_o && elapsed_time_o == 0) else $error("restore wrong");
endmodule : rdsw_switch_asserts

// file: rdsw_switch_test.sv
/*
 bench for the random delay switch.
 assumes the tick source model; picks are only known to lie in 0..limit, so limits of 0 fix timing.
*/
module rdsw_switch_test;
    timeunit 1ns;
    timeprecision 100ps;
    import rdsw_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic enable_i = 1'b0;
    logic restore_i = 1'b0;
    logic [3:0] tick_w;
    rdsw_cfg_type cfg_i = '0;
    rdsw_snap_type snap_i = '0;
    logic switch_o;
    logic [RDSW_TIME_W-1:0] elapsed_time_o;
    logic busy_o;
    rdsw_snap_type snap_w;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 core_clk_i = ~core_clk_i;
    rdsw_tick_src tick_u (.core_clk_i(core_clk_i), .tick_o(tick_w));
    rdsw_switch dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i), .tick_i(tick_w),
        .cfg_i(cfg_i), .restore_i(restore_i), .snap_i(snap_i), .snap_o(snap_w), .switch_o(switch_o),
        .elapsed_time_o(elapsed_time_o), .busy_o(busy_o));
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic test_done;
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // every timebase, source limit 0 against a large constant
    task automatic t_cycle;
        for (int tb = 0; tb < 4; tb++)
        begin
            cfg_i = '{on_src_sel: 1'b1, off_src_sel: 1'b1, max_on_delay: 16'hFFFF, max_off_delay: 16'hFFFF,
                timebase_sel: tb[1:0], default: '0};
            enable_i = 1'b1;
            step(3);
            chk("switch on", 16'h0001, {15'h0000, switch_o});
            enable_i = 1'b0;
            step(3);
            chk("switch off", 16'h0000, {15'h0000, switch_o});
        end
    endtask : t_cycle
    // one-cycle glitches on both sides must not flip the output
    task automatic t_cancel;
        enable_i = 1'b1;
        step(1);
        enable_i = 1'b0;
        step(4);
        chk("on glitch", 16'h0000, {15'h0000, switch_o});
        enable_i = 1'b1;
        step(3);
        enable_i = 1'b0;
        step(1);
        enable_i = 1'b1;
        step(4);
        chk("off glitch", 16'h0001, {15'h0000, switch_o});
    endtask : t_cancel
    // limits of three ticks: the pick is unknown but bounded, and elapsed may never pass the limit
    task automatic t_ticks;
        int n;
        cfg_i = '{max_on_delay: 16'h0003, max_off_delay: 16'h0003, timebase_sel: 2'h1, default: '0};
        for (int lvl = 0; lvl < 2; lvl++)
        begin
            enable_i = lvl[0];
            n = 0;
            while (switch_o !== lvl[0] && n < 40)
            begin
                step(1);
                n++;
                chk("elapsed bound", 16'h0001, {15'h0000, elapsed_time_o <= 16'h0003});
            end
            chk("ticked switch", {15'h0000, lvl[0]}, {15'h0000, switch_o});
        end
    endtask : t_ticks
    task automatic t_restore;
        snap_i = '{output_level: 1'b1, elapsed_time: 16'h0005, default: '0};
        for (int r = 0; r < 2; r++)
        begin
            cfg_i.retentive = r[0];
            restore_i = 1'b1;
            step(1);
            restore_i = 1'b0;
            chk("restored switch", {15'h0000, r[0]}, {15'h0000, switch_o});
            chk("restored elapsed", r[0] ? 16'h0005 : 16'h0000, elapsed_time_o);
            chk("saved elapsed", r[0] ? 16'h0005 : 16'h0000, snap_w.elapsed_time);
            chk("saved switch", {15'h0000, r[0]}, {15'h0000, snap_w.output_level});
            step(1);
        end
    endtask : t_restore
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            test_done();
        end
    end
    initial
    begin
        step(12);
        sys_rst_i = 1'b0;
        step(1);
        chk("idle busy", 16'h0000, {15'h0000, busy_o});
        chk("idle switch", 16'h0000, {15'h0000, switch_o});
        t_cycle();
        t_cancel();
        t_ticks();
        t_restore();
        test_done();
    end
endmodule : rdsw_switch_test
bind rdsw_switch rdsw_switch_asserts chk_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
    .tick_i(tick_i), .cfg_i(cfg_i), .restore_i(restore_i), .snap_i(snap_i), .switch_o(switch_o),
    .elapsed_time_o(elapsed_time_o), .busy_o(busy_o));
